// *** hw/pdu_pkg.sv ***
// package: element type codes, data unit layouts and decode functions for the codec
package pdu_pkg;
	// element type codes that select the field layout
	localparam logic [7:0] TT_INSTR             = 8'h00;
	localparam logic [7:0] TT_VARIABLE          = 8'h01;
	localparam logic [7:0] TT_CONSTANT          = 8'h02;
	localparam logic [7:0] TT_DISC_IN           = 8'h03;
	localparam logic [7:0] TT_DISC_OUT          = 8'h04;
	localparam logic [7:0] TT_CONTROL_RELAY     = 8'h05;
	localparam logic [7:0] TT_DISC_IN_PACKED    = 8'h06;
	localparam logic [7:0] TT_DISC_OUT_PACKED   = 8'h07;
	localparam logic [7:0] TT_CR_PACKED         = 8'h08;
	localparam logic [7:0] TT_WORD_INPUT        = 8'h09;
	localparam logic [7:0] TT_WORD_OUTPUT       = 8'h0A;
	localparam logic [7:0] TT_DISC_FORCE        = 8'h0B;
	localparam logic [7:0] TT_CR_FORCE          = 8'h0C;
	localparam logic [7:0] TT_WORD_FORCE        = 8'h0D;
	localparam logic [7:0] TT_TIMER_COUNTER_PRESET  = 8'h0E;
	localparam logic [7:0] TT_TIMER_COUNTER_CURRENT = 8'h0F;
	localparam logic [7:0] TT_DRUM_STEP_PRESET  = 8'h10;
	localparam logic [7:0] TT_DRUM_STEP_CURRENT = 8'h11;
	localparam logic [7:0] TT_DRUM_COUNT_PRESET = 8'h12;
	localparam logic [7:0] TT_LOOP_FIRST        = 8'h20;
	localparam logic [7:0] TT_LOOP_STATUS       = 8'h2D;

	// data unit lengths in octets; zero marks a type with no layout
	localparam logic [2:0] UB_NONE   = 3'h0;
	localparam logic [2:0] UB_OCTET  = 3'h1;
	localparam logic [2:0] UB_WORD   = 3'h2;
	localparam logic [2:0] UB_WFORCE = 3'h3;
	localparam logic [2:0] UB_FLOAT  = 3'h4;

	// location descriptor lengths in octets
	localparam logic [1:0] LB_LOOP    = 2'h1;
	localparam logic [1:0] LB_DEFAULT = 2'h2;

	localparam logic [7:0] DISC_OFF       = 8'h00;
	localparam logic [7:0] DISC_ON        = 8'h01;
	localparam logic [7:0] FRC_OFF        = 8'h00;
	localparam logic [7:0] FRC_ON         = 8'h01;
	localparam logic [7:0] FRC_OFF_FORCED = 8'h80;
	localparam logic [7:0] FRC_ON_FORCED  = 8'h81;
	localparam logic [7:0] FRC_REMOVE     = 8'hFF;
	localparam logic [7:0] WF_UNFORCED    = 8'h00;
	localparam logic [7:0] WF_FORCED_ON   = 8'h01;

	// loop status: seven flags from the top bit down, the rest spare
	localparam logic [15:0] LOOP_STAT_SPARE_MASK = 16'h01FF;

	typedef enum logic [2:0] {
		ST_TYPE  = 3'b000,
		ST_LOC   = 3'b001,
		ST_CNT   = 3'b010,
		ST_DATA  = 3'b011,
		ST_DRAIN = 3'b100
	} pdu_dev_state_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_TYPE = 3'b001,
		H_LOC  = 3'b010,
		H_CNT  = 3'b011,
		H_DATA = 3'b100
	} pdu_host_state_t;

	function automatic logic pdu_is_loop(input logic [7:0] tt);
		pdu_is_loop = (tt >= TT_LOOP_FIRST) && (tt <= TT_LOOP_STATUS);
	endfunction

	function automatic logic pdu_is_packed(input logic [7:0] tt);
		pdu_is_packed = (tt >= TT_DISC_IN_PACKED) && (tt <= TT_CR_PACKED);
	endfunction

	function automatic logic [1:0] pdu_loc_bytes(input logic [7:0] tt);
		pdu_loc_bytes = pdu_is_loop(tt) ? LB_LOOP : LB_DEFAULT;
	endfunction

	function automatic logic [2:0] pdu_unit_bytes(input logic [7:0] tt);
		if (pdu_is_loop(tt))
		begin
			pdu_unit_bytes = (tt == TT_LOOP_STATUS) ? UB_WORD : UB_FLOAT;
		end
		else
		begin
			case (tt)
				TT_INSTR, TT_VARIABLE, TT_CONSTANT, TT_WORD_INPUT, TT_WORD_OUTPUT,
				TT_TIMER_COUNTER_PRESET, TT_TIMER_COUNTER_CURRENT,
				TT_DRUM_COUNT_PRESET:
					pdu_unit_bytes = UB_WORD;
				TT_DISC_IN, TT_DISC_OUT, TT_CONTROL_RELAY, TT_DISC_IN_PACKED,
				TT_DISC_OUT_PACKED, TT_CR_PACKED, TT_DISC_FORCE, TT_CR_FORCE,
				TT_DRUM_STEP_PRESET, TT_DRUM_STEP_CURRENT:
					pdu_unit_bytes = UB_OCTET;
				TT_WORD_FORCE:
					pdu_unit_bytes = UB_WFORCE;
				default:
					pdu_unit_bytes = UB_NONE;
			endcase
		end
	endfunction
endpackage

// *** hw/pdu_link_if.sv ***
// interface: octet stream from the requesting station to the data store end
interface pdu_link_if;
	logic       h2d_valid;
	logic       h2d_ready;
	logic [7:0] h2d_data;
	logic       h2d_last;
	logic       frame_write;
	logic       frame_count_wide;

	modport host_mp (
		output h2d_valid,
		input  h2d_ready,
		output h2d_data,
		output h2d_last,
		output frame_write,
		output frame_count_wide
	);

	modport dev_mp (
		input  h2d_valid,
		output h2d_ready,
		input  h2d_data,
		input  h2d_last,
		input  frame_write,
		input  frame_count_wide
	);
endinterface

// *** hw/pdu_dev_end.sv ***
// data store end: unpacks descriptors and data units from the octet stream
// Operation
// (R1) drum count preset location: drum, then step
// (R2) input/output location descriptor is sixteen bits
// (R3) loop location descriptor is one octet
// (R4) count is one or two octets; one means one
// (R5) requester keeps requested bytes within device limit; host end only flags req_oversize and still sends
// (R6) instruction units: 16-bit steps, passed through untouched
// (R7) word-like units carried as plain 16-bit values
// (R8) unpacked discrete units: one octet, 0 off, 1 on
// (R9) packed discretes: count bits over whole octets
// (R10) discrete force octet: 00, 80, 01, 81, FF
// (R11) remove force only in writes; force optional
// (R12) word force: state octet then 16-bit value
// (R13) drum step units: one octet, within step limit
// (R14) drum count preset unit is 16 bits
// (R15) loop analog units: 32-bit excess-64 floats
// (R16) loop status unit is a 16-bit flag field
// (R17) type code octet selects the layout
// (R18) loop status spare bits are zero
// (R19) other location descriptors are sixteen bits
// (R20) packed bit order is a parameter; pad zeros
// (R21) flag short streams and undefined type codes

module pdu_dev_end #(
	parameter int         FIFO_DEPTH      = 4,
	parameter bit         PACK_LSB_FIRST  = 1'b1,
	parameter logic [7:0] DRUM_STEP_LIMIT = 8'hFF
) (
	input  wire logic        clk,
	input  wire logic        srst,
	pdu_link_if.dev_mp       link,
	output logic [7:0]       element_type_code,
	output logic [15:0]      element_location,
	output logic [15:0]      location_count,
	output logic             header_valid,
	output logic             unit_valid,
	input  wire logic        unit_ready,
	output logic [31:0]      unit_data,
	output logic             frame_done,
	output logic             err_length,
	output logic             err_type,
	output logic             err_value
);
	import pdu_pkg::*;

	pdu_dev_state_t state_q;
	logic [7:0]  tt_q;
	logic [15:0] loc_q;
	logic [15:0] cnt_q;
	logic        wr_q;
	logic        wide_q;
	logic [1:0]  idx_q;
	logic [2:0]  ulen_q;
	logic [31:0] acc_q;
	logic [15:0] units_q;
	logic        hdr_q;
	logic        done_q;
	logic        e_len_q;
	logic        e_type_q;
	logic        e_val_q;

	logic [7:0]  byte_in;
	logic        take;
	logic        fifo_in_ready;
	logic        loc_done;
	logic        cnt_done;
	logic        unit_end;
	logic        push;
	logic        bad_val;
	logic        len_fault;
	logic [2:0]  ulen_d;
	logic [31:0] acc_d;
	logic [15:0] units_d;
	logic [16:0] expect_units;
	logic [7:0]  pad_mask;

	assign byte_in = link.h2d_data;
	// a full buffer holds the stream only while data units are flowing
	assign link.h2d_ready = (state_q != ST_DATA) || fifo_in_ready;
	assign take = link.h2d_valid && link.h2d_ready;
	assign loc_done = idx_q == (pdu_loc_bytes(tt_q) - 2'h1); // [R2] [R3] [R19]
	assign cnt_done = idx_q[0] == wide_q; // [R4]
	assign push = take && (state_q == ST_DATA) && unit_end;

	always_comb
	begin
		ulen_d = ulen_q;
		if (idx_q == 2'h0)
		begin
			// a lone FF in a word force unit is a complete remove request
			if (tt_q == TT_WORD_FORCE && byte_in == FRC_REMOVE) // [R11] [R12]
				ulen_d = UB_OCTET;
			else
				ulen_d = pdu_unit_bytes(tt_q); // [R6] [R7] [R14] [R15] [R16]
		end
		acc_d = (idx_q == 2'h0) ? {24'h00_0000, byte_in} : {acc_q[23:0], byte_in};
		unit_end = ({1'h0, idx_q} + 3'h1) == ulen_d;
		units_d = units_q + 16'h0001;
		expect_units = pdu_is_packed(tt_q) ? (({1'h0, cnt_q} + 17'h0_0007) >> 3)
			: {1'h0, cnt_q}; // [R9]
		if (cnt_q[2:0] == 3'h0)
			pad_mask = 8'h00;
		else
			pad_mask = PACK_LSB_FIRST ? (8'hFF << cnt_q[2:0]) : (8'hFF >> cnt_q[2:0]);
		case (tt_q)
			TT_DISC_IN, TT_DISC_OUT, TT_CONTROL_RELAY:
				bad_val = acc_d[7:0] > DISC_ON; // [R8]
			TT_DISC_FORCE, TT_CR_FORCE:
				bad_val = !(acc_d[7:0] inside {FRC_OFF, FRC_ON, FRC_OFF_FORCED,
					FRC_ON_FORCED, FRC_REMOVE}); // [R10]
			TT_WORD_FORCE:
				bad_val = (ulen_d == UB_WFORCE) &&
					!(acc_d[23:16] inside {WF_UNFORCED, WF_FORCED_ON}); // [R12]
			TT_DRUM_STEP_PRESET, TT_DRUM_STEP_CURRENT:
				bad_val = acc_d[7:0] > DRUM_STEP_LIMIT; // [R13]
			TT_LOOP_STATUS:
				bad_val = |(acc_d[15:0] & LOOP_STAT_SPARE_MASK); // [R18]
			TT_DISC_IN_PACKED, TT_DISC_OUT_PACKED, TT_CR_PACKED:
				bad_val = ({1'h0, units_d} == expect_units) &&
					|(acc_d[7:0] & pad_mask); // [R20]
			default:
				bad_val = 1'h0;
		endcase
		// stream ending short of a complete field or unit, or, for non-instruction types, with a unit total that differs from the count (in octets if packed)
		case (state_q)
			ST_TYPE:  len_fault = 1'h1;
			ST_LOC:   len_fault = 1'h1;
			ST_CNT:   len_fault = !cnt_done || wr_q;
			ST_DATA:  len_fault = !unit_end || ((tt_q != TT_INSTR) &&
				({1'h0, units_d} != expect_units)); // [R4] [R6] [R21]
			default:  len_fault = 1'h0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			state_q <= ST_TYPE;
		else if (take)
		begin
			unique case (state_q)
				ST_TYPE:
					if (link.h2d_last)
						state_q <= ST_TYPE;
					else if (pdu_unit_bytes(byte_in) == UB_NONE) // [R17] [R21]
						state_q <= ST_DRAIN;
					else
						state_q <= ST_LOC;
				ST_LOC:
					if (link.h2d_last)
						state_q <= ST_TYPE;
					else if (loc_done)
						state_q <= ST_CNT;
				ST_CNT:
					if (link.h2d_last)
						state_q <= ST_TYPE;
					else if (cnt_done)
						state_q <= wr_q ? ST_DATA : ST_DRAIN;
				ST_DATA, ST_DRAIN:
					if (link.h2d_last)
						state_q <= ST_TYPE;
				default:
					state_q <= ST_TYPE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			idx_q <= 2'h0;
		else if (take)
		begin
			case (state_q)
				ST_LOC:  idx_q <= loc_done ? 2'h0 : idx_q + 2'h1;
				ST_CNT:  idx_q <= cnt_done ? 2'h0 : idx_q + 2'h1;
				ST_DATA: idx_q <= unit_end ? 2'h0 : idx_q + 2'h1;
				default: idx_q <= 2'h0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tt_q   <= 8'h00;
			wr_q   <= 1'h0;
			wide_q <= 1'h0;
			loc_q  <= 16'h0000;
			cnt_q  <= 16'h0000;
			hdr_q  <= 1'h0;
		end
		else if (take)
		begin
			if (state_q == ST_TYPE)
			begin
				tt_q   <= byte_in; // [R17]
				wr_q   <= link.frame_write;
				wide_q <= link.frame_count_wide;
				loc_q  <= 16'h0000;
				cnt_q  <= 16'h0000;
				hdr_q  <= 1'h0;
			end
			else if (state_q == ST_LOC)
				loc_q <= {loc_q[7:0], byte_in}; // [R1] [R2] [R3] [R19]
			else if (state_q == ST_CNT)
			begin
				cnt_q <= {cnt_q[7:0], byte_in}; // [R4]
				hdr_q <= cnt_done;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			acc_q   <= 32'h0000_0000;
			ulen_q  <= UB_NONE;
			units_q <= 16'h0000;
		end
		else if (take)
		begin
			if (state_q == ST_DATA)
			begin
				acc_q  <= acc_d;
				ulen_q <= ulen_d;
				if (unit_end)
					units_q <= units_d;
			end
			else
				units_q <= 16'h0000;
		end
	end

	// a fault wins over the clear that a new frame brings
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			done_q   <= 1'h0;
			e_len_q  <= 1'h0;
			e_type_q <= 1'h0;
			e_val_q  <= 1'h0;
		end
		else
		begin
			done_q <= take && link.h2d_last;
			if (take && state_q == ST_TYPE)
			begin
				e_len_q  <= link.h2d_last; // [R21]
				e_type_q <= pdu_unit_bytes(byte_in) == UB_NONE; // [R21]
				e_val_q  <= 1'h0;
			end
			else if (take)
			begin
				// read frames carry no data units, so extra octets are a fault
				if ((state_q == ST_CNT && cnt_done && !wr_q && !link.h2d_last) ||
					(link.h2d_last && len_fault))
					e_len_q <= 1'h1; // [R21]
				if (push && bad_val)
					e_val_q <= 1'h1;
			end
		end
	end

	pdu_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (acc_d),
		.out_valid (unit_valid),
		.out_ready (unit_ready),
		.out_data  (unit_data)
	);

	assign element_type_code = tt_q;
	assign element_location  = loc_q;
	assign location_count    = cnt_q;
	assign header_valid      = hdr_q;
	assign frame_done        = done_q;
	assign err_length        = e_len_q;
	assign err_type          = e_type_q;
	assign err_value         = e_val_q;
endmodule

// *** hw/pdu_host_end.sv ***
// requesting station end: packs a request and its data units into octets
module pdu_host_end #(
	parameter int MAX_REQ_BYTES = 270
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [7:0]  cmd_type,
	input  wire logic        cmd_write,
	input  wire logic        cmd_count_wide,
	input  wire logic [15:0] cmd_location,
	input  wire logic [15:0] cmd_count,
	input  wire logic        wdata_valid,
	output logic             wdata_ready,
	input  wire logic [31:0] wdata,
	input  wire logic        wdata_last,
	output logic             req_oversize,
	pdu_link_if.host_mp      link
);
	import pdu_pkg::*;

	pdu_host_state_t st_q;
	logic [7:0]  tt_q;
	logic [15:0] loc_q;
	logic [15:0] cnt_q;
	logic        wr_q;
	logic        wide_q;
	logic [1:0]  idx_q;
	logic [31:0] sh_q;
	logic [2:0]  ulen_q;
	logic        ld_q;
	logic        lastu_q;
	logic        ov_q;
	logic [7:0]  od_q;
	logic        ol_q;
	logic        over_q;

	logic        slot;
	logic        have;
	logic        emit;
	logic        fdone;
	logic        nlast;
	logic [7:0]  nbyte;
	logic [31:0] shifted;
	logic        remove;
	logic [18:0] req_bytes;

	assign slot = !ov_q || link.h2d_ready;
	assign cmd_ready = st_q == H_IDLE;
	assign wdata_ready = (st_q == H_DATA) && !ld_q;
	assign emit = have && slot;
	assign remove = (tt_q == TT_WORD_FORCE) && (wdata[23:16] == FRC_REMOVE); // [R12]
	assign shifted = sh_q >> {ulen_q - 3'h1 - {1'h0, idx_q}, 3'h0};

	always_comb
	begin
		have  = 1'h0;
		nbyte = 8'h00;
		nlast = 1'h0;
		fdone = 1'h0;
		case (st_q)
			H_TYPE:
			begin
				have  = 1'h1;
				nbyte = tt_q;
				fdone = 1'h1;
			end
			H_LOC:
			begin
				have  = 1'h1;
				fdone = idx_q == (pdu_loc_bytes(tt_q) - 2'h1); // [R2] [R3] [R19]
				nbyte = (idx_q == 2'h0 && !fdone) ? loc_q[15:8] : loc_q[7:0]; // [R1]
			end
			H_CNT:
			begin
				have  = 1'h1;
				fdone = idx_q[0] == wide_q; // [R4]
				nbyte = (idx_q == 2'h0 && wide_q) ? cnt_q[15:8] : cnt_q[7:0];
				nlast = fdone && !wr_q;
			end
			H_DATA:
			begin
				have  = ld_q;
				fdone = ({1'h0, idx_q} + 3'h1) == ulen_q;
				nbyte = shifted[7:0];
				nlast = fdone && lastu_q;
			end
			default:
				have = 1'h0;
		endcase
		// advisory size of what the request asks the far end for
		if (pdu_is_packed(cmd_type))
			req_bytes = 19'(({1'h0, cmd_count} + 17'h0_0007) >> 3);
		else
			req_bytes = 19'(cmd_count) * 19'(pdu_unit_bytes(cmd_type));
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st_q <= H_IDLE;
		else
		begin
			unique case (st_q)
				H_IDLE:
					if (cmd_valid)
						st_q <= H_TYPE;
				H_TYPE:
					if (emit)
						st_q <= H_LOC;
				H_LOC:
					if (emit && fdone)
						st_q <= H_CNT;
				H_CNT:
					if (emit && fdone)
						st_q <= wr_q ? H_DATA : H_IDLE;
				H_DATA:
					if (emit && fdone && lastu_q)
						st_q <= H_IDLE;
				default:
					st_q <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tt_q   <= 8'h00;
			loc_q  <= 16'h0000;
			cnt_q  <= 16'h0000;
			wr_q   <= 1'h0;
			wide_q <= 1'h0;
			over_q <= 1'h0;
		end
		else if (st_q == H_IDLE && cmd_valid)
		begin
			tt_q   <= cmd_type; // [R17]
			loc_q  <= cmd_location;
			cnt_q  <= cmd_count;
			wr_q   <= cmd_write;
			wide_q <= cmd_count_wide;
			over_q <= 32'(req_bytes) > MAX_REQ_BYTES; // [R5]
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			idx_q <= 2'h0;
		else if (emit)
			idx_q <= fdone ? 2'h0 : idx_q + 2'h1;
	end

	// units are right-aligned in wdata and sent most significant octet first
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sh_q    <= 32'h0000_0000;
			ulen_q  <= UB_NONE;
			ld_q    <= 1'h0;
			lastu_q <= 1'h0;
		end
		else if (wdata_valid && wdata_ready)
		begin
			sh_q    <= remove ? {24'h00_0000, FRC_REMOVE} : wdata; // [R11] [R6] [R7]
			ulen_q  <= remove ? UB_OCTET : pdu_unit_bytes(tt_q); // [R15] [R16]
			ld_q    <= 1'h1;
			lastu_q <= wdata_last;
		end
		else if (emit && fdone && st_q == H_DATA)
			ld_q <= 1'h0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ov_q <= 1'h0;
			od_q <= 8'h00;
			ol_q <= 1'h0;
		end
		else if (emit)
		begin
			ov_q <= 1'h1;
			od_q <= nbyte;
			ol_q <= nlast;
		end
		else if (link.h2d_ready)
			ov_q <= 1'h0;
	end

	assign link.h2d_valid        = ov_q;
	assign link.h2d_data         = od_q;
	assign link.h2d_last         = ol_q;
	assign link.frame_write      = wr_q;
	assign link.frame_count_wide = wide_q;
	assign req_oversize          = over_q;
endmodule

// small stream buffer for the data store end; depth must be a power of two
module pdu_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;

	assign in_ready  = (wr_q - rd_q) != FULL_LVL;
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (in_valid && in_ready)
				wr_q <= wr_q + 1'h1;
			if (out_valid && out_ready)
				rd_q <= rd_q + 1'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (in_valid && in_ready)
			mem_q[wr_q[AW-1:0]] <= in_data;
	end
endmodule

// *** verification/pdu_link_props.sv ***
// checker: octet framing and handshake properties on the link between the two ends
module pdu_link_props (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       h2d_valid,
	input wire logic       h2d_ready,
	input wire logic [7:0] h2d_data,
	input wire logic       h2d_last,
	input wire logic       frame_write,
	input wire logic       frame_count_wide
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] idx_q;
	logic [7:0] type_q;
	logic [7:0] cur_t;
	logic [7:0] hdr_len;
	logic [7:0] umask;
	logic       is_loop;
	logic       take;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	assign take    = h2d_valid && h2d_ready;
	assign cur_t   = (idx_q == 8'h00) ? h2d_data : type_q;
	assign is_loop = (cur_t >= 8'h20) && (cur_t <= 8'h2D);
	// type octet, one or two location octets, one or two count octets
	assign hdr_len = (is_loop ? 8'h02 : 8'h03) + (frame_count_wide ? 8'h02 : 8'h01);

	// only fixed multi-octet units are checked; one-octet and word force units may end anywhere
	always_comb
	begin
		case (cur_t)
			8'h00, 8'h01, 8'h02, 8'h09, 8'h0A, 8'h0E, 8'h0F, 8'h12, 8'h2D: umask = 8'h01;
			default: umask = is_loop ? 8'h03 : 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst || (take && h2d_last))
			idx_q <= 8'h00;
		else if (take)
			idx_q <= idx_q + 8'h01;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			type_q <= 8'h00;
		else if (take && (idx_q == 8'h00))
			type_q <= h2d_data;
	end

	sequence s_stall;
		h2d_valid && !h2d_ready;
	endsequence
	sequence s_mid;
		h2d_valid && h2d_ready && !h2d_last;
	endsequence

	property p_hold;
		s_stall |=> h2d_valid && $stable(h2d_data) && $stable(h2d_last);
	endproperty
	property p_rst;
		$fell(srst) |-> h2d_ready && !h2d_valid && !frame_write;
	endproperty
	property p_side;
		s_mid |=> $stable(frame_write) && $stable(frame_count_wide);
	endproperty
	property p_burst;
		s_mid ##0 (idx_q + 8'h01 < hdr_len) |=> h2d_valid;
	endproperty
	property p_rd_last;
		h2d_valid && !frame_write && (idx_q + 8'h01 == hdr_len) |-> h2d_last;
	endproperty
	property p_no_early;
		h2d_valid && (idx_q + 8'h01 < hdr_len) |-> !h2d_last;
	endproperty
	property p_unit_whole;
		h2d_valid && h2d_last && frame_write && (umask != 8'h00)
			|-> (idx_q >= hdr_len) && (((idx_q + 8'h01 - hdr_len) & umask) == 8'h00);
	endproperty
	property p_ready;
		!h2d_ready |-> frame_write && (idx_q >= hdr_len);
	endproperty

	a_hold: assert property (p_hold) else $error("octet changed while stalled");
	a_rst: assert property (p_rst) else $error("link not idle after reset");
	a_side: assert property (p_side) else $error("frame sideband moved mid frame");
	a_burst: assert property (p_burst) else $error("gap inside header");
	a_rd_last: assert property (p_rd_last) else $error("read frame length wrong");
	a_no_early: assert property (p_no_early) else $error("frame ended in header");
	a_unit_whole: assert property (p_unit_whole) else $error("frame ended mid unit");
	a_ready: assert property (p_ready) else $error("device stalled outside data");
endmodule

// *** verification/testbench.sv ***
// testbench: host end packs requests, device end unpacks them across the link
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pdu_pkg::*;

	typedef struct {
		logic [7:0]  tt;
		logic [1:0]  mode;
		logic [15:0] loc;
		logic [15:0] cnt;
		int          n;
		logic [31:0] u [5];
		logic [3:0]  flg;
	} pdu_row_t;

	logic        clk;
	logic        srst;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [7:0]  cmd_type;
	logic        cmd_write;
	logic        cmd_count_wide;
	logic [15:0] cmd_location;
	logic [15:0] cmd_count;
	logic        wdata_valid;
	logic        wdata_ready;
	logic [31:0] wdata;
	logic        wdata_last;
	logic        req_oversize;
	logic [7:0]  element_type_code;
	logic [15:0] element_location;
	logic [15:0] location_count;
	logic        header_valid;
	logic        unit_valid;
	logic        unit_ready;
	logic [31:0] unit_data;
	logic        frame_done;
	logic        err_length;
	logic        err_type;
	logic        err_value;
	logic [31:0] got [$];
	int          mismatches = 0;
	int          n_checks = 0;

	// mode is {write, wide count}; flg is {length, type, value errors, oversize}
	pdu_row_t rows [12] = '{
		'{TT_DRUM_COUNT_PRESET, 2'h2, 16'h0307, 16'h0001, 1, '{32'hBEEF, '0, '0, '0, '0}, 4'h0},
		'{TT_WORD_INPUT, 2'h1, 16'h1234, 16'h0100, 0, '{'0, '0, '0, '0, '0}, 4'h1},
		'{TT_LOOP_FIRST, 2'h2, 16'h0005, 16'h0001, 1, '{32'h4110_0000, '0, '0, '0, '0}, 4'h0},
		'{TT_LOOP_STATUS, 2'h2, 16'h0002, 16'h0001, 1, '{32'hFE00, '0, '0, '0, '0}, 4'h0},
		'{TT_INSTR, 2'h2, 16'h0100, 16'h0001, 2, '{32'h1111, 32'h2222, '0, '0, '0}, 4'h0},
		'{TT_VARIABLE, 2'h2, 16'h0040, 16'h0002, 2, '{32'hAAAA, 32'h5555, '0, '0, '0}, 4'h0},
		'{TT_DISC_IN, 2'h2, 16'h0001, 16'h0002, 2, '{32'h1, 32'h0, '0, '0, '0}, 4'h0},
		'{TT_DISC_IN_PACKED, 2'h2, 16'h0008, 16'h000A, 2, '{32'hFF, 32'h3, '0, '0, '0}, 4'h0},
		'{TT_DISC_FORCE, 2'h2, 16'h0010, 16'h0005, 5, '{32'h0, 32'h80, 32'h1, 32'h81, 32'hFF}, 4'h0},
		'{TT_WORD_FORCE, 2'h2, 16'h0020, 16'h0003, 3, '{32'h1234, 32'h1_5678, 32'hFF_0000, '0, '0},
			4'h0},
		'{TT_DRUM_STEP_CURRENT, 2'h2, 16'h0102, 16'h0001, 1, '{32'h5, '0, '0, '0, '0}, 4'h0},
		'{TT_TIMER_COUNTER_PRESET, 2'h0, 16'h0010, 16'h0003, 0, '{'0, '0, '0, '0, '0}, 4'h0}
	};

	pdu_link_if pdu_link_if_inst ();
	pdu_host_end pdu_host_end_inst (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_type(cmd_type), .cmd_write(cmd_write),
		.cmd_count_wide(cmd_count_wide), .cmd_location(cmd_location), .cmd_count(cmd_count),
		.wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata),
		.wdata_last(wdata_last), .req_oversize(req_oversize), .link(pdu_link_if_inst));
	pdu_dev_end pdu_dev_end_inst (.clk(clk), .srst(srst), .link(pdu_link_if_inst),
		.element_type_code(element_type_code), .element_location(element_location),
		.location_count(location_count), .header_valid(header_valid), .unit_valid(unit_valid),
		.unit_ready(unit_ready), .unit_data(unit_data), .frame_done(frame_done),
		.err_length(err_length), .err_type(err_type), .err_value(err_value));
	pdu_link_props pdu_link_props_inst (.clk(clk), .srst(srst),
		.h2d_valid(pdu_link_if_inst.h2d_valid), .h2d_ready(pdu_link_if_inst.h2d_ready),
		.h2d_data(pdu_link_if_inst.h2d_data), .h2d_last(pdu_link_if_inst.h2d_last),
		.frame_write(pdu_link_if_inst.frame_write),
		.frame_count_wide(pdu_link_if_inst.frame_count_wide));

	task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_flag(input string name, input logic exp, input logic seen);
		check_word(name, {31'h0, exp}, {31'h0, seen});
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if ((mismatches == 0) && (n_checks > 0))
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic run_row(input pdu_row_t r);
		logic [31:0] e;
		@(posedge clk);
		cmd_type <= r.tt;
		cmd_write <= r.mode[1];
		cmd_count_wide <= r.mode[0];
		cmd_location <= r.loc;
		cmd_count <= r.cnt;
		cmd_valid <= 1'h1;
		do @(negedge clk); while (!cmd_ready);
		@(posedge clk);
		cmd_valid <= 1'h0;
		// valid stays up between units; the design itself inserts the gap
		for (int i = 0; i < r.n; i++)
		begin
			wdata <= r.u[i];
			wdata_last <= (i == r.n - 1);
			wdata_valid <= 1'h1;
			do @(negedge clk); while (!wdata_ready);
			@(posedge clk);
		end
		wdata_valid <= 1'h0;
		do @(negedge clk); while (!frame_done);
		if (!r.flg[2])
		begin
			check_word("type", r.tt, element_type_code);
			check_word("location", r.loc, element_location);
			check_word("count", r.cnt, location_count);
			check_flag("header", 1'h1, header_valid);
		end
		check_flag("err_length", r.flg[3], err_length);
		check_flag("err_type", r.flg[2], err_type);
		check_flag("err_value", r.flg[1], err_value);
		check_flag("oversize", r.flg[0], req_oversize);
		repeat (6) @(posedge clk);
		if (r.flg[3:1] == 3'h0)
		begin
			check_word("units", 32'(r.n), 32'(got.size()));
			foreach (got[i])
			begin
				e = ((r.tt == TT_WORD_FORCE) && (r.u[i][23:16] == 8'hFF)) ? 32'hFF : r.u[i];
				check_word("unit", e, got[i]);
			end
		end
		got.delete();
	endtask

	task automatic bad(input logic [7:0] tt, input logic [1:0] md, input logic [15:0] c,
			input logic [31:0] u0, input logic [3:0] f);
		run_row('{tt, md, 16'h0010, c, int'(md[1]), '{u0, '0, '0, '0, '0}, f});
	endtask

	always @(posedge clk)
	begin
		if (!srst && unit_valid && unit_ready)
			got.push_back(unit_data);
	end

	initial
	begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		finish_test();
	end

	initial
	begin
		{srst, unit_ready, cmd_valid, cmd_write, cmd_count_wide, wdata_valid, wdata_last} = 7'h60;
		{cmd_type, cmd_location, cmd_count, wdata} = '0;
		repeat (16) @(posedge clk);
		srst <= 1'h0;
		foreach (rows[i])
			run_row(rows[i]);
		bad(8'h13, 2'h0, 16'h0001, '0, 4'h4);
		bad(TT_DISC_OUT, 2'h2, 16'h0001, 32'h2, 4'h2);
		bad(TT_CR_PACKED, 2'h2, 16'h0003, 32'h8, 4'h2);
		bad(TT_WORD_FORCE, 2'h2, 16'h0001, 32'h2_1234, 4'h2);
		// the far side stalls: the buffer fills and the link must back off
		@(posedge clk);
		unit_ready <= 1'h0;
		fork
			run_row('{TT_VARIABLE, 2'h3, 16'h0200, 16'h0005, 5,
				'{32'h101, 32'h202, 32'h303, 32'h404, 32'h505}, 4'h0});
			begin
				repeat (40) @(negedge clk);
				check_flag("link_ready", 1'h0, pdu_link_if_inst.h2d_ready);
				@(posedge clk);
				unit_ready <= 1'h1;
			end
		join
		bad(TT_VARIABLE, 2'h2, 16'h0003, 32'h7777, 4'h8);
		@(posedge clk);
		srst <= 1'h1;
		repeat (16) @(posedge clk);
		srst <= 1'h0;
		@(negedge clk);
		check_flag("err_length", 1'h0, err_length);
		check_flag("header", 1'h0, header_valid);
		check_flag("cmd_ready", 1'h1, cmd_ready);
		run_row(rows[0]);
		finish_test();
	end
endmodule
